// ---- hw/bcg_pkg.sv ----
// Constants and types shared by the bridge configuration and pin command block.
package bcg_pkg;

    // Function codes carried in the first byte after the address.
    localparam logic [7:0] FN_SPI_CONFIG  = 8'hF0;
    localparam logic [7:0] FN_IRQ_CLEAR   = 8'hF1;
    localparam logic [7:0] FN_IDLE        = 8'hF2;
    localparam logic [7:0] FN_PIN_WRITE   = 8'hF4;
    localparam logic [7:0] FN_PIN_SAMPLE  = 8'hF5;
    localparam logic [7:0] FN_PIN_ENABLE  = 8'hF6;
    localparam logic [7:0] FN_PIN_DRIVE   = 8'hF7;

    // Settings byte field positions.
    localparam int SET_ORDER_BIT = 5;
    localparam int SET_MODE_LSB  = 2;
    localparam int SET_RATE_LSB  = 0;

    // Drive type codes, two bits per pin.
    localparam logic [1:0] DRV_QUASI     = 2'h0;
    localparam logic [1:0] DRV_PUSH_PULL = 2'h1;
    localparam logic [1:0] DRV_INPUT     = 2'h2;
    localparam logic [1:0] DRV_OPEN      = 2'h3;

    // Clock rate and SPI clock frequencies in kHz.
    localparam int CLK_KHZ      = 100000;
    localparam int SPI_KHZ_0    = 1843;
    localparam int SPI_KHZ_1    = 461;
    localparam int SPI_KHZ_2    = 115;
    localparam int SPI_KHZ_3    = 58;
    // Half periods of the SPI clock in system cycles, rounded down.
    localparam logic [15:0] HALF_0 = 16'(CLK_KHZ / (2 * SPI_KHZ_0));
    localparam logic [15:0] HALF_1 = 16'(CLK_KHZ / (2 * SPI_KHZ_1));
    localparam logic [15:0] HALF_2 = 16'(CLK_KHZ / (2 * SPI_KHZ_2));
    localparam logic [15:0] HALF_3 = 16'(CLK_KHZ / (2 * SPI_KHZ_3));

    // Strong pull-up window after a zero-to-one latch change, in cycles.
    localparam logic [1:0] STRONG_PU_CYCLES = 2'h2;
    // Cycles after reset before the address straps are taken.
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    // Index of the last bit in a byte and the acknowledge slot index.
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;
    // Fixed upper part of the slave address.
    localparam logic [3:0] ADDR_FIXED = 4'h5;

    // Two-wire receiver states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_DATA = 4'h4,
        ST_SKIP = 4'h8
    } bcg_state_t;

    // Link domain state.
    typedef struct packed {
        logic [7:0] shift;
        logic       tog;
    } bcg_link_t;

    // System domain state.
    typedef struct packed {
        logic [2:0]  scl_sy;
        logic [2:0]  sda_sy;
        logic [2:0]  tog_sy;
        logic [3:0]  pin_m;
        logic [3:0]  pin_s;
        logic [2:0]  strap_m;
        logic [2:0]  strap_s;
        logic [1:0]  strap_wait;
        logic [2:0]  addr_lo;
        bcg_state_t  ist;
        logic [3:0]  bitcnt;
        logic        ack_pend;
        logic        sda_drv_b;
        logic [1:0]  byte_idx;
        logic [7:0]  func;
        logic [7:0]  arg;
        logic        has_func;
        logic        has_arg;
        logic [7:0]  busy_cnt;
        logic        busy;
        logic        low_power;
        logic        irq_drv_b;
        logic        lsb_first;
        logic [1:0]  mode;
        logic        trail;
        logic [1:0]  rate;
        logic [15:0] half_per;
        logic [3:0]  gpio_en;
        logic [3:0]  latch;
        logic [7:0]  dtype;
        logic [7:0]  strong_cnt;
        logic [3:0]  pin_o;
        logic [3:0]  pin_oe_b;
        logic [3:0]  weak_pu;
        logic [3:0]  vweak_pu;
        logic [3:0]  strong_pu;
        logic [7:0]  samp;
        logic        samp_stb;
    } bcg_core_t;

endpackage

// ---- hw/bcg_bridge_cfg.sv ----
// Configuration and pin command interpreter behind the two-wire slave port.
`timescale 1ns/1ps
`default_nettype none

module bcg_bridge_cfg #(
    parameter logic [7:0] EXEC_CYCLES = 8'h10
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        scl,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_b,
    input  wire logic [2:0]  addr_strap_i,
    input  wire logic [3:0]  ss_i,
    output logic [3:0]       ss_o,
    output logic [3:0]       ss_oe_b,
    output logic [3:0]       ss_weak_pu,
    output logic [3:0]       ss_very_weak_pu,
    output logic [3:0]       ss_strong_pu,
    output logic             irq_o,
    output logic             irq_oe_b,
    input  wire logic [3:0]  spi_ss_b_i,
    input  wire logic        spi_done_i,
    output logic             spi_lsb_first,
    output logic [1:0]       spi_clock_mode_field,
    output logic [1:0]       spi_rate_select,
    output logic [15:0]      spi_half_period,
    output logic             spi_sample_trailing,
    output logic             spi_clock_out,
    output logic             low_power,
    output logic             busy,
    output logic [7:0]       buf_wr_data,
    output logic             buf_wr_stb
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: bits are shifted in on the rising edge of the bus clock.

    bcg_pkg::bcg_link_t link_r;
    bcg_pkg::bcg_link_t link_nxt;
    bcg_pkg::bcg_core_t core_r;
    bcg_pkg::bcg_core_t core_nxt;

    // Each rising edge shifts data in and flips the toggle seen by the core.
    // The core reads the shift register only after the toggle has crossed, when the
    // byte has stood still for several system cycles, so no word crosses unguarded.
    always_comb begin
        link_nxt       = link_r;
        link_nxt.shift = {link_r.shift[6:0], sda_i};
        link_nxt.tog   = ~link_r.tog;
    end

    // The bus clock stands still during reset, so this reset acts without it.
    always_ff @(posedge scl or negedge rst_b) begin
        if (!rst_b) begin
            link_r <= '0;
        end else begin
            link_r <= link_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Half period of the SPI clock for a rate code.
    function automatic logic [15:0] rate_half(input logic [1:0] sel);
        logic [15:0] h;
        h = bcg_pkg::HALF_0;
        case (sel)
            2'h0: h = bcg_pkg::HALF_0;
            2'h1: h = bcg_pkg::HALF_1;
            2'h2: h = bcg_pkg::HALF_2;
            default: h = bcg_pkg::HALF_3;
        endcase
        return h;
    endfunction

    // True when the seven address bits just shifted in name this device.
    function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] lo);
        return b[7:1] == {bcg_pkg::ADDR_FIXED, lo};
    endfunction

    // Reset image of the core state.
    function automatic bcg_pkg::bcg_core_t core_reset();
        bcg_pkg::bcg_core_t c;
        c           = '0;
        c.scl_sy    = 3'h7;
        c.sda_sy    = 3'h7;
        c.ist       = bcg_pkg::ST_IDLE;
        c.sda_drv_b = 1'b1;
        c.irq_drv_b = 1'b1;
        c.half_per  = rate_half(2'h0);
        c.pin_o     = 4'hF;
        c.pin_oe_b  = 4'h0;
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Core next-state logic.

    logic start_ev;
    logic stop_ev;
    logic bit_ev;
    logic scl_fall;
    logic [1:0] fld;
    logic [1:0] scnt;

    always_comb begin
        core_nxt = core_r;
        fld      = 2'h0;
        scnt     = 2'h0;
        // Three flops on the bus lines and the toggle, two on pins and straps; only the later flops are read below.
        core_nxt.scl_sy  = {core_r.scl_sy[1:0], scl};
        core_nxt.sda_sy  = {core_r.sda_sy[1:0], sda_i};
        core_nxt.tog_sy  = {core_r.tog_sy[1:0], link_r.tog};
        core_nxt.pin_m   = ss_i;
        core_nxt.pin_s   = core_r.pin_m;
        core_nxt.strap_m = addr_strap_i;
        core_nxt.strap_s = core_r.strap_m;
        start_ev = core_r.scl_sy[1] && core_r.sda_sy[2] && !core_r.sda_sy[1];
        stop_ev  = core_r.scl_sy[1] && !core_r.sda_sy[2] && core_r.sda_sy[1];
        scl_fall = core_r.scl_sy[2] && !core_r.scl_sy[1];
        bit_ev   = core_r.tog_sy[2] ^ core_r.tog_sy[1];
        core_nxt.samp_stb = 1'b0;

        // Address straps are caught once, after they have passed the synchroniser.
        if (core_r.strap_wait != bcg_pkg::STRAP_WAIT) begin
            core_nxt.strap_wait = core_r.strap_wait + 2'h1;
            core_nxt.addr_lo    = core_r.strap_s;
        end

        // Execution time countdown.
        if (core_r.busy_cnt != 8'h00) begin
            core_nxt.busy_cnt = core_r.busy_cnt - 8'h01;
        end

        // Acknowledge drive: low after the eighth clock falls, off after the ninth.
        if (scl_fall) begin
            if (core_r.bitcnt == bcg_pkg::BIT_ACK && core_r.ack_pend) begin
                core_nxt.sda_drv_b = 1'b0;
            end else if (core_r.bitcnt == 4'h0) begin
                core_nxt.sda_drv_b = 1'b1;
            end
        end

        // Bit framing and byte handling.
        if (bit_ev && core_r.ist != bcg_pkg::ST_IDLE) begin
            if (core_r.bitcnt == bcg_pkg::BIT_ACK) begin
                core_nxt.bitcnt   = 4'h0;
                core_nxt.ack_pend = 1'b0;
            end else begin
                core_nxt.bitcnt = core_r.bitcnt + 4'h1;
            end
            if (core_r.bitcnt == bcg_pkg::BIT_LAST) begin
                case (core_r.ist)
                    bcg_pkg::ST_ADDR: begin
                        if (addr_hit(link_r.shift, core_r.addr_lo)) begin
                            core_nxt.low_power = 1'b0;
                        end
                        if (addr_hit(link_r.shift, core_r.addr_lo)
                            && !link_r.shift[0] && !core_r.busy) begin
                            core_nxt.ack_pend = 1'b1;
                            core_nxt.ist      = bcg_pkg::ST_DATA;
                            core_nxt.byte_idx = 2'h0;
                            core_nxt.has_func = 1'b0;
                            core_nxt.has_arg  = 1'b0;
                        end else begin
                            core_nxt.ist = bcg_pkg::ST_SKIP;
                        end
                    end
                    bcg_pkg::ST_DATA: begin
                        core_nxt.ack_pend = 1'b1;
                        // First byte is the function, the next its argument.
                        if (core_r.byte_idx == 2'h0) begin
                            core_nxt.func     = link_r.shift;
                            core_nxt.has_func = 1'b1;
                            core_nxt.byte_idx = 2'h1;
                        end else if (core_r.byte_idx == 2'h1) begin
                            core_nxt.arg      = link_r.shift;
                            core_nxt.has_arg  = 1'b1;
                            core_nxt.byte_idx = 2'h2;
                        end
                    end
                    default: begin
                        core_nxt.ack_pend = 1'b0;
                    end
                endcase
            end
        end

        // A start, repeated or not, opens a new address phase.
        if (start_ev) begin
            core_nxt.ist       = bcg_pkg::ST_ADDR;
            core_nxt.bitcnt    = 4'h0;
            core_nxt.ack_pend  = 1'b0;
            core_nxt.sda_drv_b = 1'b1;
        end

        // A stop executes the function collected in this message.
        if (stop_ev) begin
            core_nxt.ist       = bcg_pkg::ST_IDLE;
            core_nxt.sda_drv_b = 1'b1;
            core_nxt.ack_pend  = 1'b0;
            if (core_r.ist == bcg_pkg::ST_DATA && core_r.has_func) begin
                core_nxt.busy_cnt = EXEC_CYCLES;
                case (core_r.func)
                    bcg_pkg::FN_SPI_CONFIG: begin
                        if (core_r.has_arg) begin
                            core_nxt.lsb_first = core_r.arg[bcg_pkg::SET_ORDER_BIT];
                            core_nxt.mode = core_r.arg[bcg_pkg::SET_MODE_LSB +: 2];
                            core_nxt.trail = ^core_r.arg[bcg_pkg::SET_MODE_LSB +: 2];
                            core_nxt.rate = core_r.arg[bcg_pkg::SET_RATE_LSB +: 2];
                            core_nxt.half_per =
                                rate_half(core_r.arg[bcg_pkg::SET_RATE_LSB +: 2]);
                        end
                    end
                    bcg_pkg::FN_IRQ_CLEAR: begin
                        core_nxt.irq_drv_b = 1'b1;
                    end
                    bcg_pkg::FN_IDLE: begin
                        core_nxt.low_power = 1'b1;
                    end
                    bcg_pkg::FN_PIN_WRITE: begin
                        if (core_r.has_arg) begin
                            core_nxt.latch = (core_r.latch & ~core_r.gpio_en)
                                           | (core_r.arg[3:0] & core_r.gpio_en);
                        end
                    end
                    bcg_pkg::FN_PIN_SAMPLE: begin
                        core_nxt.samp     = {4'h0, core_r.pin_s};
                        core_nxt.samp_stb = 1'b1;
                    end
                    bcg_pkg::FN_PIN_ENABLE: begin
                        if (core_r.has_arg) begin
                            core_nxt.gpio_en = core_r.arg[3:0];
                            for (int i = 0; i < 4; i++) begin
                                if (core_r.arg[i] && !core_r.gpio_en[i]) begin
                                    core_nxt.dtype[2*i +: 2] = bcg_pkg::DRV_QUASI;
                                end
                            end
                        end
                    end
                    bcg_pkg::FN_PIN_DRIVE: begin
                        if (core_r.has_arg) begin
                            core_nxt.dtype = core_r.arg;
                        end
                    end
                    default: begin
                        // Unknown codes do nothing, so the host is not held off.
                        core_nxt.busy_cnt = 8'h00;
                    end
                endcase
            end
        end
        core_nxt.busy = (core_nxt.busy_cnt != 8'h00);

        // Transfer completion wins over a clear in the same cycle.
        if (spi_done_i) begin
            core_nxt.irq_drv_b = 1'b0;
        end

        // A pin that leaves quasi drive loses any strong pull-up window at once.
        // Pin drive, per pin, from the new latch, type and use.
        for (int i = 0; i < 4; i++) begin
            fld  = core_nxt.dtype[2*i +: 2];
            scnt = core_r.strong_cnt[2*i +: 2];
            if (scnt != 2'h0) begin
                scnt = scnt - 2'h1;
            end
            if (core_nxt.gpio_en[i] && fld == bcg_pkg::DRV_QUASI
                && !core_r.latch[i] && core_nxt.latch[i]) begin
                scnt = bcg_pkg::STRONG_PU_CYCLES;
            end
            if (!core_nxt.gpio_en[i] || fld != bcg_pkg::DRV_QUASI) begin
                scnt = 2'h0;
            end
            core_nxt.strong_cnt[2*i +: 2] = scnt;
            core_nxt.weak_pu[i]   = 1'b0;
            core_nxt.vweak_pu[i]  = 1'b0;
            core_nxt.strong_pu[i] = 1'b0;
            if (!core_nxt.gpio_en[i]) begin
                core_nxt.pin_o[i]    = spi_ss_b_i[i];
                core_nxt.pin_oe_b[i] = 1'b0;
            end else begin
                case (fld)
                    bcg_pkg::DRV_QUASI: begin
                        // Strong high only inside the window, else low or released.
                        core_nxt.strong_pu[i] = (scnt != 2'h0);
                        core_nxt.pin_o[i]     = (scnt != 2'h0);
                        core_nxt.pin_oe_b[i]  = core_nxt.latch[i] && (scnt == 2'h0);
                        core_nxt.vweak_pu[i]  = core_nxt.latch[i];
                        core_nxt.weak_pu[i]   = core_nxt.latch[i] && core_r.pin_s[i];
                    end
                    bcg_pkg::DRV_PUSH_PULL: begin
                        core_nxt.pin_o[i]    = core_nxt.latch[i];
                        core_nxt.pin_oe_b[i] = 1'b0;
                    end
                    bcg_pkg::DRV_INPUT: begin
                        core_nxt.pin_o[i]    = 1'b0;
                        core_nxt.pin_oe_b[i] = 1'b1;
                    end
                    default: begin
                        core_nxt.pin_o[i]    = 1'b0;
                        core_nxt.pin_oe_b[i] = core_nxt.latch[i];
                    end
                endcase
            end
        end
    end

    // Core state register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_r <= core_reset();
        end else begin
            core_r <= core_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a core flip-flop except sda_o and irq_o, which are tied low.

    assign sda_o                = 1'b0;
    assign sda_oe_b             = core_r.sda_drv_b;
    assign ss_o                 = core_r.pin_o;
    assign ss_oe_b              = core_r.pin_oe_b;
    assign ss_weak_pu           = core_r.weak_pu;
    assign ss_very_weak_pu      = core_r.vweak_pu;
    assign ss_strong_pu         = core_r.strong_pu;
    assign irq_o                = 1'b0;
    assign irq_oe_b             = core_r.irq_drv_b;
    assign spi_lsb_first        = core_r.lsb_first;
    assign spi_clock_mode_field = core_r.mode;
    assign spi_rate_select      = core_r.rate;
    assign spi_half_period      = core_r.half_per;
    // Trailing-edge flag is registered with the mode; bit 1 gives the idle level.
    assign spi_sample_trailing  = core_r.trail;
    assign spi_clock_out        = core_r.mode[1];
    assign low_power            = core_r.low_power;
    assign busy                 = core_r.busy;
    assign buf_wr_data          = core_r.samp;
    assign buf_wr_stb           = core_r.samp_stb;

endmodule

`default_nettype wire

// ---- tb/bcg_bridge_cfg_asserts.sv ----
// Port-level checks for the bridge configuration block.
`timescale 1ns/1ps
`default_nettype none
module bcg_bridge_cfg_asserts (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        sda_oe_b,
    input wire logic [3:0]  ss_oe_b,
    input wire logic [3:0]  ss_weak_pu,
    input wire logic [3:0]  ss_very_weak_pu,
    input wire logic [3:0]  ss_strong_pu,
    input wire logic        irq_oe_b,
    input wire logic        spi_done_i,
    input wire logic [1:0]  spi_clock_mode_field,
    input wire logic [1:0]  spi_rate_select,
    input wire logic [15:0] spi_half_period,
    input wire logic        spi_sample_trailing,
    input wire logic        spi_clock_out,
    input wire logic        low_power,
    input wire logic        busy
);
    // Everything runs on the system clock and is quiet while reset is held.
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    // Each check ties an output to its cause; a flipped condition trips one.
    property p_rst;
        $rose(rst_b) |-> ss_oe_b == 4'h0 && irq_oe_b && !busy && !low_power;
    endproperty
    a_rst: assert property (p_rst) else $error("state after reset wrong");
    property p_nack_busy; busy |-> sda_oe_b; endproperty
    a_nack_busy: assert property (p_nack_busy) else $error("ack while busy");
    property p_irq; spi_done_i |=> !irq_oe_b; endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
    property p_trail; spi_sample_trailing == ^spi_clock_mode_field; endproperty
    a_trail: assert property (p_trail) else $error("sampling edge wrong");
    property p_idle_lvl; spi_clock_out == spi_clock_mode_field[1]; endproperty
    a_idle_lvl: assert property (p_idle_lvl) else $error("clock idle level wrong");
    property p_half;
        spi_half_period == (spi_rate_select == 2'h0 ? 16'h001B : spi_rate_select == 2'h1 ?
            16'h006C : spi_rate_select == 2'h2 ? 16'h01B2 : 16'h035E);
    endproperty
    a_half: assert property (p_half) else $error("clock rate wrong");
    property p_strong;
        $rose(ss_strong_pu[0]) |-> !ss_oe_b[0] ##1 ss_strong_pu[0] ##1 !ss_strong_pu[0];
    endproperty
    a_strong: assert property (p_strong) else $error("strong pull-up not two cycles");
    property p_weak; (ss_weak_pu & ~ss_very_weak_pu) == 4'h0; endproperty
    a_weak: assert property (p_weak) else $error("weak pull-up without latch");
endmodule
bind bcg_bridge_cfg bcg_bridge_cfg_asserts u_chk (.*);
`default_nettype wire

// ---- tb/bcg_host_model.sv ----
// Behavioural two-wire bus master that writes command messages.
`timescale 1ns/1ps
`default_nettype none
module bcg_host_model (
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda_i
);
    // Between messages both lines rest released, high on their pull-ups.
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    ////////////////////////////////////////
    // Phases of 80 ns keep every bit well inside the device's synchronisers.
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_m = b[i];
            #40 scl = 1'b1;
            #80 scl = 1'b0;
            #40;
        end
        sda_m = 1'b1;
        #40 scl = 1'b1;
        #40 ack = !sda_i;
        #40 scl = 1'b0;
        #40;
    endtask
    // START, address, up to two bytes, STOP; the acks of data bytes are not needed.
    task automatic msg(input logic [7:0] ad, input logic [7:0] fn, input logic [7:0] ag,
                       input int n, output logic ack);
        logic a2;
        sda_m = 1'b0;
        #80 scl = 1'b0;
        #40;
        put_byte(ad, ack);
        if (n > 0) put_byte(fn, a2);
        if (n > 1) put_byte(ag, a2);
        sda_m = 1'b0;
        #40 scl = 1'b1;
        #80 sda_m = 1'b1;
        #160;
    endtask
endmodule
`default_nettype wire

// ---- tb/bcg_bridge_cfg_bench.sv ----
// Self-checking bench for the bridge configuration block.
`timescale 1ns/1ps
`default_nettype none
module bcg_bridge_cfg_bench;
    logic        clk, rst_b, scl, sda_m, sda_i, sda_o, sda_oe_b, ack, irq_o, irq_oe_b;
    logic        spi_done_i, spi_lsb_first, spi_sample_trailing, spi_clock_out;
    logic        low_power, busy, buf_wr_stb;
    logic [1:0]  spi_clock_mode_field, spi_rate_select;
    logic [2:0]  addr_strap_i;
    logic [3:0]  ss_i, ss_o, ss_oe_b, ss_weak_pu, ss_very_weak_pu, ss_strong_pu;
    logic [3:0]  spi_ss_b_i, ext_low;
    logic [7:0]  buf_wr_data, arg;
    logic [15:0] spi_half_period, note, expv;
    logic [15:0] exp_q[$];
    logic [15:0] half_tab[4] = '{16'h001B, 16'h006C, 16'h01B2, 16'h035E};
    int          failures, checked;

    bcg_bridge_cfg #(.EXEC_CYCLES(8'hF0)) uut (.*);
    bcg_host_model host (.scl, .sda_m, .sda_i);
    // Open-drain data wire; released pins rest high unless ext_low pulls them.
    assign sda_i = sda_m & (sda_oe_b | sda_o);
    assign ss_i = (~ss_oe_b & ss_o) | (ss_oe_b & ~ext_low);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////
    // Counts one comparison and reports a difference at once.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // A message expected to be taken first waits out busy, so it is never refused.
    task automatic cmd(input logic [7:0] fn, input logic [7:0] ag, input int n, input logic want);
        for (int k = 0; k < 300 && want && busy !== 1'b0; k++) begin
            @(posedge clk);
            #1;
        end
        host.msg(8'h54, fn, ag, n, ack);
        chk(16'(ack), 16'(want), "ack");
        repeat (6) @(posedge clk);
        #1;
    endtask
    // Takes the oldest noted pin sample whenever the buffer strobe shows.
    always @(posedge clk) begin
        if (buf_wr_stb === 1'b1) begin
            note = exp_q.size() > 0 ? exp_q.pop_front() : 16'hFFFF;
            chk(16'(buf_wr_data & note[15:8]), 16'(note[7:0]), "sample");
        end
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // A hung handshake ends here; the whole run needs well under this.
    initial begin
        #400us;
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end
    // Reset, port settings, interrupt and idle, then the general-purpose pins.
    initial begin
        rst_b = 1'b0;
        spi_done_i = 1'b0;
        addr_strap_i = 3'h2;
        ext_low = 4'h0;
        void'($urandom(32'h7293));
        spi_ss_b_i = 4'($urandom);
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk({ss_oe_b, ss_o, 7'h00, irq_oe_b}, {4'h0, spi_ss_b_i, 8'h01}, "reset");
        for (int k = 0; k < 4; k++) begin
            arg = {4'($urandom), 2'(3 - k), 2'(k)};
            cmd(bcg_pkg::FN_SPI_CONFIG, arg, 2, 1'b1);
            chk(spi_half_period, half_tab[k], "rate");
            expv = 16'({arg[5], arg[3:0]});
            chk(16'({spi_lsb_first, spi_clock_mode_field, spi_rate_select}), expv, "set");
            chk(16'({spi_sample_trailing, spi_clock_out}), 16'({^arg[3:2], arg[3]}), "mode");
            cmd(8'h00, 8'h00, 0, 1'b0);
        end
        $display("test settings done");
        @(posedge clk);
        #1 spi_done_i = 1'b1;
        @(posedge clk);
        #1 spi_done_i = 1'b0;
        chk(16'({irq_o, irq_oe_b}), 16'h0000, "irq set");
        cmd(bcg_pkg::FN_IRQ_CLEAR, 8'h00, 1, 1'b1);
        chk(16'(irq_oe_b), 16'h0001, "irq clear");
        cmd(bcg_pkg::FN_IDLE, 8'h00, 1, 1'b1);
        chk(16'(low_power), 16'h0001, "idle in");
        cmd(8'h00, 8'h00, 0, 1'b1);
        chk(16'(low_power), 16'h0000, "idle out");
        $display("test interrupt and idle done");
        ext_low = 4'h1;
        cmd(bcg_pkg::FN_PIN_ENABLE, 8'hF5, 2, 1'b1);
        chk({8'h00, ss_oe_b, ss_o}, {12'h000, spi_ss_b_i & 4'hA}, "enable");
        cmd(bcg_pkg::FN_PIN_WRITE, 8'hFF, 2, 1'b1);
        expv = {12'h554, spi_ss_b_i & 4'hA};
        chk({ss_oe_b, ss_very_weak_pu, ss_weak_pu, ss_o & 4'hA}, expv, "quasi");
        exp_q.push_back(16'h0504);
        cmd(bcg_pkg::FN_PIN_SAMPLE, 8'h00, 1, 1'b1);
        ext_low = 4'h0;
        cmd(bcg_pkg::FN_PIN_DRIVE, 8'hB1, 2, 1'b1);
        chk(16'({ss_oe_b[2], ss_oe_b[0], ss_o[0]}), 16'h0005, "types");
        cmd(bcg_pkg::FN_PIN_WRITE, 8'h00, 2, 1'b1);
        chk(16'({ss_oe_b[2], ss_o[2], ss_oe_b[0], ss_o[0]}), 16'h0000, "low");
        cmd(bcg_pkg::FN_PIN_ENABLE, 8'h00, 2, 1'b1);
        chk({8'h00, ss_oe_b, ss_o}, {12'h000, spi_ss_b_i}, "select");
        chk(16'(exp_q.size()), 16'h0000, "samples");
        $display("test pins done");
        wrap_up();
    end
endmodule
`default_nettype wire
